// [core/ops_defs.vh]
// constants for the output driver power sequencer and mixer routing
`ifndef OPS_DEFS_VH
`define OPS_DEFS_VH

// register offsets inside the page, and the page that holds them
`define OPS_PAGE_SEL_OFS     8'h00
`define OPS_SEQ_PAGE         8'h01
`define OPS_POP_TIMING_OFS   8'h21
`define OPS_RAMP_DOWN_OFS    8'h22
`define OPS_ROUTING_OFS      8'h23

// reset values
`define OPS_PAGE_SEL_RST     8'h00
`define OPS_POP_TIMING_RST   8'h3e
`define OPS_RAMP_DOWN_RST    8'h00
`define OPS_ROUTING_RST      8'h00

// field positions, pop removal timing register
`define OPS_PDN_ORDER_BIT    7
`define OPS_PON_DLY_HI       6
`define OPS_PON_DLY_LO       3
`define OPS_RAMP_STEP_HI     2
`define OPS_RAMP_STEP_LO     1
`define OPS_CM_SRC_BIT       0
// field positions, ramp down period register
`define OPS_SP_WAIT_HI       6
`define OPS_SP_WAIT_LO       4
// field positions, routing register
`define OPS_LDAC_HI          7
`define OPS_LDAC_LO          6
`define OPS_IN1_LEFT_BIT     5
`define OPS_IN2_LEFT_BIT     4
`define OPS_RDAC_HI          3
`define OPS_RDAC_LO          2
`define OPS_IN2_RIGHT_BIT    1
`define OPS_DIFF_BIT         0

// converter route codes
`define OPS_ROUTE_MIXER      2'h1
`define OPS_ROUTE_DIRECT     2'h2

// nominal oscillator and system clock, in kHz
`define OPS_NOM_OSC_KHZ      8200
`define OPS_CLK_KHZ          25000

// headphone power-on delays, in units of 0.1 us
`define OPS_PON_T1           153
`define OPS_PON_T2           1530
`define OPS_PON_T3           15300
`define OPS_PON_T4           153000
`define OPS_PON_T5           762000
`define OPS_PON_T6           1530000
`define OPS_PON_T7           3040000
`define OPS_PON_T8           6100000
`define OPS_PON_T9           12200000
`define OPS_PON_T10          30400000
`define OPS_PON_T11          61000000
// headphone ramp-up step times, 0.1 us
`define OPS_STEP_T1          9800
`define OPS_STEP_T2          19500
`define OPS_STEP_T3          39000
// speaker power-up waits, 0.1 us
`define OPS_SPW_T1           30400
`define OPS_SPW_T2           76200
`define OPS_SPW_T3           122000
`define OPS_SPW_T4           153000
`define OPS_SPW_T5           198000
`define OPS_SPW_T6           244000
`define OPS_SPW_T7           305000

`endif

// [core/ops_sequencer.v]
// output driver power sequencer with pop timing and mixer routing
// Operation
// R01 - power-down order bit delays converter shutdown
// R02 - four-bit headphone power-on delay, reset 0111
// R03 - software avoids reserved delay codes 1100-1111
// R04 - two-bit headphone ramp step time, reset 11
// R05 - durations scale with actual oscillator frequency
// R06 - software keeps common-mode source bit zero
// R07 - three-bit speaker power-up wait, reset 000
// R08 - software writes reserved ramp-down bits unchanged
// R09 - left converter route: off, mixer, headphone
// R10 - first analog input to left mixer
// R11 - second analog input to left mixer
// R12 - right converter route: off, mixer, headphone
// R13 - second analog input to right mixer
// R14 - left headphone feeds right for differential
// R15 - page one selected before these writes
// R16 - stages advance only when tick count expires
`timescale 1ns/1ps
`include "ops_defs.vh"

module ops_sequencer #(
	parameter CLK_KHZ    = `OPS_CLK_KHZ,     // system clock rate
	parameter OSC_KHZ    = `OPS_NOM_OSC_KHZ, // actual oscillator rate
	parameter TIME_DIV   = 1,                // shortens all stages in sim
	parameter RAMP_STEPS = 8                 // gain steps per ramp
) (
	input  wire       clk,
	input  wire       reset_n,
	input  wire [7:0] reg_addr,        // byte offset in current page
	input  wire       reg_wr_en,       // write strobe, one cycle
	input  wire [7:0] reg_wdata,
	input  wire       reg_rd_en,       // read strobe, one cycle
	output reg  [7:0] reg_rdata_q,     // valid the cycle after strobe
	input  wire       hp_power_req,    // headphone power-up requested
	input  wire       sp_power_req,    // speaker power-up requested
	input  wire       dac_power_req,   // converter power-up requested
	input  wire       pdn_seq_start,   // software power-down pulse
	output reg        hp_drv_enable_q, // headphone driver biased
	output reg  [3:0] hp_gain_step_q,  // ramp position, 0 is silent
	output reg        hp_on_q,         // ramp complete
	output reg        sp_on_q,         // speaker amplifier up
	output reg        dac_enable_q,    // converter powered
	output reg        pdn_busy_q,      // power-down sequence running
	output reg        left_dac_to_mixer_q,
	output reg        left_dac_to_left_headphone_driver_q,
	output reg        right_dac_to_mixer_q,
	output reg        right_dac_to_right_headphone_driver_q,
	output reg        first_analog_input_to_left_mixer_q,
	output reg        second_analog_input_to_left_mixer_q,
	output reg        second_analog_input_to_right_mixer_q,
	output reg        left_to_right_headphone_driver_q
);

	localparam CW = 26;  // fits 6.1 s of oscillator ticks

	// headphone states
	localparam [2:0] HP_IDLE  = 3'd0;
	localparam [2:0] HP_DELAY = 3'd1;
	localparam [2:0] HP_RAMPU = 3'd2;
	localparam [2:0] HP_ON    = 3'd3;
	localparam [2:0] HP_RAMPD = 3'd4;
	// speaker states
	localparam [1:0] SP_OFF   = 2'd0;
	localparam [1:0] SP_WAIT  = 2'd1;
	localparam [1:0] SP_ON    = 2'd2;

	localparam [3:0] TOP_STEP = RAMP_STEPS[3:0];
	localparam [3:0] ONE_STEP = 4'h1;
	localparam [15:0] OSC_INC = OSC_KHZ[15:0];
	localparam [15:0] CLK_MOD = CLK_KHZ[15:0];

	// converts 0.1 us units to nominal oscillator ticks, at least one for a nonzero time
	function [CW-1:0] ticks;
		input [31:0] t;
		reg   [63:0] p;
		begin
			p = ({32'h0, t} * `OPS_NOM_OSC_KHZ) / (64'd10000 * TIME_DIV);
			if (t != 32'h0 && p == 64'h0) begin
				p = 64'h1;
			end
			ticks = p[CW-1:0];
		end
	endfunction

	reg [7:0]    page_q;        // page select
	reg [7:0]    pop_q;         // pop removal timing
	reg [7:0]    rdn_q;         // ramp down period control
	reg [7:0]    route_q;       // mixer routing
	reg [15:0]   acc_q;         // oscillator phase accumulator
	reg          tick_q;        // one oscillator period
	reg [2:0]    hp_st_q;
	reg [1:0]    sp_st_q;
	reg          hp_tstart;     // timer loads, combinational
	reg [CW-1:0] hp_tload;
	reg          sp_tstart;
	reg [CW-1:0] pon_ticks;     // selected power-on delay
	reg [CW-1:0] step_ticks;    // selected ramp step
	reg [CW-1:0] spw_ticks;     // selected speaker wait
	wire         hp_done;
	wire         sp_done;
	wire [16:0]  acc_sum;
	wire         on_page;
	wire         hp_want;
	wire         sp_want;
	wire         amps_off;

	assign on_page  = (page_q == `OPS_SEQ_PAGE);
	assign hp_want  = hp_power_req && !pdn_busy_q;
	assign sp_want  = sp_power_req && !pdn_busy_q;
	assign amps_off = (hp_st_q == HP_IDLE) && (sp_st_q == SP_OFF);
	assign acc_sum  = {1'b0, acc_q} + {1'b0, OSC_INC};

	// register writes; the target page must be selected first
	always @(posedge clk) begin
		if (!reset_n) begin
			page_q  <= `OPS_PAGE_SEL_RST;
			pop_q   <= `OPS_POP_TIMING_RST;   // [R02] [R04]
			rdn_q   <= `OPS_RAMP_DOWN_RST;    // [R07]
			route_q <= `OPS_ROUTING_RST;
		end else if (reg_wr_en) begin
			if (reg_addr == `OPS_PAGE_SEL_OFS) begin
				page_q <= reg_wdata;
			end else if (on_page && reg_addr == `OPS_POP_TIMING_OFS) begin
				pop_q <= reg_wdata;   // reserved codes stored as is [R03] [R06]
			end else if (on_page && reg_addr == `OPS_RAMP_DOWN_OFS) begin
				rdn_q <= reg_wdata;   // reserved bits kept for readback [R08]
			end else if (on_page && reg_addr == `OPS_ROUTING_OFS) begin
				route_q <= reg_wdata; // [R15]
			end
		end
	end

	// register reads; unmapped offsets read zero
	always @(posedge clk) begin
		if (!reset_n) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd_en) begin
			if (reg_addr == `OPS_PAGE_SEL_OFS) begin
				reg_rdata_q <= page_q;
			end else if (on_page && reg_addr == `OPS_POP_TIMING_OFS) begin
				reg_rdata_q <= pop_q;
			end else if (on_page && reg_addr == `OPS_RAMP_DOWN_OFS) begin
				reg_rdata_q <= rdn_q;
			end else if (on_page && reg_addr == `OPS_ROUTING_OFS) begin
				reg_rdata_q <= route_q;
			end else begin
				reg_rdata_q <= 8'h00;
			end
		end
	end

	// oscillator model: ticks at OSC_KHZ while counts assume nominal,
	// so a slow or fast oscillator stretches or shrinks every stage alike
	always @(posedge clk) begin
		if (!reset_n) begin
			acc_q  <= 16'h0000;
			tick_q <= 1'b0;
		end else if (acc_sum >= {1'b0, CLK_MOD}) begin
			acc_q  <= acc_sum[15:0] - CLK_MOD;   // [R05]
			tick_q <= 1'b1;
		end else begin
			acc_q  <= acc_sum[15:0];
			tick_q <= 1'b0;
		end
	end

	// delay tables; codes 1100-1111 fall back to the longest delay
	always @* begin
		case (pop_q[`OPS_PON_DLY_HI:`OPS_PON_DLY_LO])   // [R02]
		4'h0: pon_ticks = {CW{1'b0}};
		4'h1: pon_ticks = ticks(`OPS_PON_T1);
		4'h2: pon_ticks = ticks(`OPS_PON_T2);
		4'h3: pon_ticks = ticks(`OPS_PON_T3);
		4'h4: pon_ticks = ticks(`OPS_PON_T4);
		4'h5: pon_ticks = ticks(`OPS_PON_T5);
		4'h6: pon_ticks = ticks(`OPS_PON_T6);
		4'h7: pon_ticks = ticks(`OPS_PON_T7);
		4'h8: pon_ticks = ticks(`OPS_PON_T8);
		4'h9: pon_ticks = ticks(`OPS_PON_T9);
		4'ha: pon_ticks = ticks(`OPS_PON_T10);
		default: pon_ticks = ticks(`OPS_PON_T11);
		endcase
		case (pop_q[`OPS_RAMP_STEP_HI:`OPS_RAMP_STEP_LO])   // [R04]
		2'h0: step_ticks = {CW{1'b0}};
		2'h1: step_ticks = ticks(`OPS_STEP_T1);
		2'h2: step_ticks = ticks(`OPS_STEP_T2);
		default: step_ticks = ticks(`OPS_STEP_T3);
		endcase
		case (rdn_q[`OPS_SP_WAIT_HI:`OPS_SP_WAIT_LO])   // [R07]
		3'h0: spw_ticks = {CW{1'b0}};
		3'h1: spw_ticks = ticks(`OPS_SPW_T1);
		3'h2: spw_ticks = ticks(`OPS_SPW_T2);
		3'h3: spw_ticks = ticks(`OPS_SPW_T3);
		3'h4: spw_ticks = ticks(`OPS_SPW_T4);
		3'h5: spw_ticks = ticks(`OPS_SPW_T5);
		3'h6: spw_ticks = ticks(`OPS_SPW_T6);
		default: spw_ticks = ticks(`OPS_SPW_T7);
		endcase
	end

	// timer loads for the headphone and speaker stages
	always @* begin
		hp_tstart = 1'b0;
		hp_tload  = step_ticks;
		sp_tstart = (sp_st_q == SP_OFF) && sp_want;
		case (hp_st_q)
		HP_IDLE: begin
			hp_tstart = hp_want;
			hp_tload  = pon_ticks;
		end
		HP_DELAY: hp_tstart = hp_want && hp_done;
		HP_RAMPU: hp_tstart = hp_done || !hp_want;
		HP_ON:    hp_tstart = !hp_want;
		HP_RAMPD: hp_tstart = hp_done || hp_want;
		default:  hp_tstart = 1'b0;
		endcase
	end

	ops_stage_timer #(.CW(CW)) u_hp_timer (
		.clk      (clk),
		.reset_n  (reset_n),
		.start    (hp_tstart),
		.load_val (hp_tload),
		.tick     (tick_q),
		.done_q   (hp_done)
	);

	ops_stage_timer #(.CW(CW)) u_sp_timer (
		.clk      (clk),
		.reset_n  (reset_n),
		.start    (sp_tstart),
		.load_val (spw_ticks),
		.tick     (tick_q),
		.done_q   (sp_done)
	);

	// headphone driver: delay, ramp up step by step, hold, ramp down
	always @(posedge clk) begin
		if (!reset_n) begin
			hp_st_q         <= HP_IDLE;
			hp_gain_step_q  <= 4'h0;
			hp_drv_enable_q <= 1'b0;
			hp_on_q         <= 1'b0;
		end else begin
			case (hp_st_q)
			HP_IDLE: if (hp_want) begin
				hp_st_q         <= HP_DELAY;
				hp_drv_enable_q <= 1'b1;
			end
			HP_DELAY: if (!hp_want) begin
				hp_st_q         <= HP_IDLE;   // abort, nothing ramped yet
				hp_drv_enable_q <= 1'b0;
			end else if (hp_done) begin
				hp_st_q <= HP_RAMPU;          // [R16]
			end
			HP_RAMPU: if (!hp_want) begin
				hp_st_q <= HP_RAMPD;
			end else if (hp_done) begin
				hp_gain_step_q <= hp_gain_step_q + ONE_STEP;   // [R16]
				if (hp_gain_step_q + ONE_STEP == TOP_STEP) begin
					hp_st_q <= HP_ON;
					hp_on_q <= 1'b1;
				end
			end
			HP_ON: if (!hp_want) begin
				hp_st_q <= HP_RAMPD;
				hp_on_q <= 1'b0;
			end
			HP_RAMPD: if (hp_want) begin
				hp_st_q <= HP_RAMPU;          // resume from current step
			end else if (hp_done) begin
				if (hp_gain_step_q <= ONE_STEP) begin
					hp_gain_step_q  <= 4'h0;
					hp_st_q         <= HP_IDLE;   // [R16]
					hp_drv_enable_q <= 1'b0;
				end else begin
					hp_gain_step_q <= hp_gain_step_q - ONE_STEP;
				end
			end
			default: hp_st_q <= HP_IDLE;
			endcase
		end
	end

	// speaker: enabled only after the wait expires
	always @(posedge clk) begin
		if (!reset_n) begin
			sp_st_q <= SP_OFF;
			sp_on_q <= 1'b0;
		end else if (!sp_want) begin
			sp_st_q <= SP_OFF;
			sp_on_q <= 1'b0;
		end else if (sp_st_q == SP_OFF) begin
			sp_st_q <= SP_WAIT;
		end else if (sp_st_q == SP_WAIT && sp_done) begin
			sp_st_q <= SP_ON;   // [R07] [R16]
			sp_on_q <= 1'b1;
		end
	end

	// converter power and the software power-down sequence
	always @(posedge clk) begin
		if (!reset_n) begin
			pdn_busy_q   <= 1'b0;
			dac_enable_q <= 1'b0;
		end else begin
			if (pdn_seq_start) begin
				pdn_busy_q <= 1'b1;   // start wins over the release
			end else if (pdn_busy_q && amps_off && !dac_enable_q &&
				!hp_power_req && !sp_power_req && !dac_power_req) begin
				pdn_busy_q <= 1'b0;   // held until software drops requests
			end
			if (!pdn_busy_q && !pdn_seq_start) begin
				dac_enable_q <= dac_power_req;
			end else if (!pop_q[`OPS_PDN_ORDER_BIT] || amps_off) begin
				dac_enable_q <= 1'b0;   // [R01]
			end
		end
	end

	// routing switches; reserved code 11 leaves a converter open
	always @(posedge clk) begin
		if (!reset_n) begin
			left_dac_to_mixer_q                   <= 1'b0;
			left_dac_to_left_headphone_driver_q   <= 1'b0;
			right_dac_to_mixer_q                  <= 1'b0;
			right_dac_to_right_headphone_driver_q <= 1'b0;
			first_analog_input_to_left_mixer_q    <= 1'b0;
			second_analog_input_to_left_mixer_q   <= 1'b0;
			second_analog_input_to_right_mixer_q  <= 1'b0;
			left_to_right_headphone_driver_q      <= 1'b0;
		end else begin
			left_dac_to_mixer_q <=
				route_q[`OPS_LDAC_HI:`OPS_LDAC_LO] == `OPS_ROUTE_MIXER;  // [R09]
			left_dac_to_left_headphone_driver_q <=
				route_q[`OPS_LDAC_HI:`OPS_LDAC_LO] == `OPS_ROUTE_DIRECT; // [R09]
			right_dac_to_mixer_q <=
				route_q[`OPS_RDAC_HI:`OPS_RDAC_LO] == `OPS_ROUTE_MIXER;  // [R12]
			right_dac_to_right_headphone_driver_q <=
				route_q[`OPS_RDAC_HI:`OPS_RDAC_LO] == `OPS_ROUTE_DIRECT; // [R12]
			first_analog_input_to_left_mixer_q <=
				route_q[`OPS_IN1_LEFT_BIT];   // [R10]
			second_analog_input_to_left_mixer_q <=
				route_q[`OPS_IN2_LEFT_BIT];   // [R11]
			second_analog_input_to_right_mixer_q <=
				route_q[`OPS_IN2_RIGHT_BIT];  // [R13]
			left_to_right_headphone_driver_q <=
				route_q[`OPS_DIFF_BIT];     // [R14]
		end
	end

endmodule

// [core/ops_stage_timer.v]
// stage timer counting oscillator ticks down to a done pulse
`timescale 1ns/1ps
`include "ops_defs.vh"

module ops_stage_timer #(
	parameter CW = 26
) (
	input  wire          clk,
	input  wire          reset_n,
	input  wire          start,     // load a new count
	input  wire [CW-1:0] load_val,  // ticks to wait, zero allowed
	input  wire          tick,      // one oscillator period elapsed
	output reg           done_q     // one-cycle pulse at expiry
);

	reg [CW-1:0] cnt_q;   // ticks left
	reg          busy_q;  // a stage is being timed

	// a start always wins, so a restart never sees a stale done
	always @(posedge clk) begin
		if (!reset_n) begin
			cnt_q  <= {CW{1'b0}};
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (start) begin
			cnt_q  <= load_val;
			busy_q <= 1'b1;
			done_q <= 1'b0;
		end else if (busy_q && cnt_q == {CW{1'b0}}) begin
			busy_q <= 1'b0;   // expired
			done_q <= 1'b1;
		end else begin
			done_q <= 1'b0;
			if (busy_q && tick) begin
				cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule

// [testbench/ops_monitor.sv]
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module ops_monitor #(
	parameter RAMP_STEPS = 8
) (
	input wire       clk,
	input wire       reset_n,
	input wire [7:0] reg_addr,
	input wire       reg_wr_en,
	input wire [7:0] reg_wdata,
	input wire       pdn_seq_start,
	input wire       pdn_busy_q,
	input wire       dac_enable_q,
	input wire       hp_on_q,
	input wire [3:0] hp_gain_step_q,
	input wire       left_dac_to_mixer_q,
	input wire       left_dac_to_left_headphone_driver_q,
	input wire       right_dac_to_mixer_q,
	input wire       right_dac_to_right_headphone_driver_q,
	input wire       first_analog_input_to_left_mixer_q,
	input wire       second_analog_input_to_left_mixer_q,
	input wire       second_analog_input_to_right_mixer_q,
	input wire       left_to_right_headphone_driver_q
);
	reg  [7:0] page_q; // page select shadow
	reg        ord_q;  // power-down order shadow
	reg  [7:0] wd_q;   // last routing byte accepted
	reg  [7:0] wx_q;   // that byte one edge later, as the switches show it
	wire       rt_wr = reg_wr_en && page_q == 8'h01 && reg_addr == 8'h23;
	wire [7:0] rt = {left_dac_to_mixer_q, left_dac_to_left_headphone_driver_q,
		right_dac_to_mixer_q, right_dac_to_right_headphone_driver_q,
		first_analog_input_to_left_mixer_q, second_analog_input_to_left_mixer_q,
		second_analog_input_to_right_mixer_q, left_to_right_headphone_driver_q};
	// shadows follow accepted writes only, so wrong-page writes are seen
	always @(posedge clk) begin
		if (!reset_n) begin
			page_q <= 8'h00;
			ord_q <= 1'b0;
			wd_q <= 8'h00;
		end else if (reg_wr_en) begin
			if (reg_addr == 8'h00)
				page_q <= reg_wdata;
			if (page_q == 8'h01 && reg_addr == 8'h21)
				ord_q <= reg_wdata[7];
			if (rt_wr)
				wd_q <= reg_wdata;
		end
	end
	// switches lag the register by one edge, so compare two edges on
	always @(posedge clk)
		wx_q <= wd_q;
	default clocking dc @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_left_route: assert property (rt_wr |-> ##2
		rt[7:6] == {wx_q[7:6] == 2'h1, wx_q[7:6] == 2'h2})
		else $error("left converter route wrong");
	a_first_in_left: assert property (rt_wr |-> ##2 rt[3] == wx_q[5])
		else $error("first input switch wrong");
	a_second_in_left: assert property (rt_wr |-> ##2 rt[2] == wx_q[4])
		else $error("second input left switch wrong");
	a_right_route: assert property (rt_wr |-> ##2
		rt[5:4] == {wx_q[3:2] == 2'h1, wx_q[3:2] == 2'h2})
		else $error("right converter route wrong");
	a_second_in_right: assert property (rt_wr |-> ##2 rt[1] == wx_q[1])
		else $error("second input right switch wrong");
	a_diff_path: assert property (rt_wr |-> ##2 rt[0] == wx_q[0])
		else $error("differential path wrong");
	a_route_hold: assert property (!rt_wr && !$past(rt_wr) |=>
		$stable(rt))
		else $error("routing moved without a write");
	a_pdn_busy: assert property (pdn_seq_start |=> pdn_busy_q)
		else $error("power-down not flagged");
	a_dac_with_amps: assert property (pdn_seq_start && !ord_q |=>
		!dac_enable_q)
		else $error("converter not down at once");
	a_dac_after_amps: assert property (pdn_seq_start && ord_q &&
		dac_enable_q && hp_on_q |=> dac_enable_q)
		else $error("converter down before amplifiers");
	a_ramp_single: assert property ($past(reset_n) &&
		$changed(hp_gain_step_q) |->
		(hp_gain_step_q - $past(hp_gain_step_q) == 4'h1 ||
		$past(hp_gain_step_q) - hp_gain_step_q == 4'h1))
		else $error("ramp skipped a step");
	a_on_at_top: assert property (hp_on_q |->
		hp_gain_step_q == RAMP_STEPS)
		else $error("ramp done flag off the top");
endmodule
bind ops_sequencer ops_monitor #(.RAMP_STEPS(RAMP_STEPS)) u_ops_monitor (
	.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
	.pdn_seq_start(pdn_seq_start), .pdn_busy_q(pdn_busy_q),
	.dac_enable_q(dac_enable_q), .hp_on_q(hp_on_q),
	.hp_gain_step_q(hp_gain_step_q),
	.left_dac_to_mixer_q(left_dac_to_mixer_q),
	.left_dac_to_left_headphone_driver_q(left_dac_to_left_headphone_driver_q),
	.right_dac_to_mixer_q(right_dac_to_mixer_q),
	.right_dac_to_right_headphone_driver_q(
		right_dac_to_right_headphone_driver_q),
	.first_analog_input_to_left_mixer_q(first_analog_input_to_left_mixer_q),
	.second_analog_input_to_left_mixer_q(second_analog_input_to_left_mixer_q),
	.second_analog_input_to_right_mixer_q(second_analog_input_to_right_mixer_q),
	.left_to_right_headphone_driver_q(left_to_right_headphone_driver_q));

// [testbench/testbench.sv]
// self-checking bench for the output driver sequencer
`timescale 1ns/1ps
module testbench;
	localparam int TDIV = 100; // shrinks every stage count
	logic       clk;
	logic       reset_n;
	logic [7:0] addr;
	logic       wr_en;
	logic [7:0] wdata;
	logic       rd_en;
	logic       hp_req;
	logic       sp_req;
	logic       dac_req;
	logic       pdn;
	wire  [7:0] rdata;
	wire        hp_en;
	wire  [3:0] step;
	wire        hp_on;
	wire        sp_on;
	wire        dac_en;
	wire        busy;
	wire  [7:0] rt;      // routing switches, left mixer first
	logic [7:0] rq[$];   // expected read bytes, oldest first
	logic       rd_d1;
	logic       rd_d2;
	logic [7:0] r;
	logic [7:0] e;
	int         bad_count;
	int         checks_done;
	int         cyc;
	int         d;
	int         s;
	int         pon[5] = '{0, 153, 1530, 15300, 153000}; // 0.1 us units
	int         stp[4] = '{0, 9800, 19500, 39000};
	int         spw[8] = '{0, 30400, 76200, 122000, 153000, 198000,
		244000, 305000};
	ops_sequencer #(.CLK_KHZ(25000), .OSC_KHZ(12500), .TIME_DIV(TDIV),
		.RAMP_STEPS(8)) u_ops_sequencer (
		.clk(clk), .reset_n(reset_n), .reg_addr(addr), .reg_wr_en(wr_en),
		.reg_wdata(wdata), .reg_rd_en(rd_en), .reg_rdata_q(rdata),
		.hp_power_req(hp_req), .sp_power_req(sp_req),
		.dac_power_req(dac_req), .pdn_seq_start(pdn),
		.hp_drv_enable_q(hp_en), .hp_gain_step_q(step), .hp_on_q(hp_on),
		.sp_on_q(sp_on), .dac_enable_q(dac_en), .pdn_busy_q(busy),
		.left_dac_to_mixer_q(rt[7]),
		.left_dac_to_left_headphone_driver_q(rt[6]),
		.right_dac_to_mixer_q(rt[5]),
		.right_dac_to_right_headphone_driver_q(rt[4]),
		.first_analog_input_to_left_mixer_q(rt[3]),
		.second_analog_input_to_left_mixer_q(rt[2]),
		.second_analog_input_to_right_mixer_q(rt[1]),
		.left_to_right_headphone_driver_q(rt[0]));
	// clock at 25 MHz
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// one comparison, counted; a miss is reported at once
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// a count inside the window passes as lo, else the count shows
	task automatic rng(input int v, input int lo, input int hi);
		chk((v >= lo && v <= hi) ? lo : v, lo);
	endtask
	// clocks for a duration: oscillator ticks at half the clock rate
	function automatic int tk(input int u);
		int t;
		t = u * 82 / 100 / TDIV;
		if (u != 0 && t == 0)
			t = 1;
		return 2 * t;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		addr = a;
		wdata = v;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
	endtask
	// spaced so the answer stands a full cycle before the watcher looks
	task automatic rd(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		addr = a;
		rd_en = 1'b1;
		rq.push_back(v);
		@(negedge clk);
		rd_en = 1'b0;
		@(negedge clk);
	endtask
	// watcher: takes the oldest note when a read answer is due
	always @(posedge clk) begin
		rd_d1 <= rd_en;
		rd_d2 <= rd_d1;
	end
	always @(negedge clk) begin
		if (rd_d2 === 1'b1 && rq.size() > 0)
			chk(rdata, rq.pop_front());
	end
	// headphone up to step two, then back down to idle
	task automatic hp_run(input logic [7:0] v, output int dl, output int sl);
		int n;
		wr(8'h21, v);
		hp_req = 1'b1;
		dl = 0;
		while (step === 4'h0 && dl < 20000) begin
			@(negedge clk);
			dl++;
		end
		sl = 0;
		while (step !== 4'h2 && sl < 20000) begin
			@(negedge clk);
			sl++;
		end
		chk({hp_en, hp_on}, 2'b10);
		hp_req = 1'b0;
		n = 0;
		while (hp_en !== 1'b0 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		chk(step, 4'h0);
	endtask
	task automatic sp_run(input logic [2:0] c);
		int n;
		wr(8'h22, {1'b0, c, 4'h0});
		sp_req = 1'b1;
		n = 0;
		while (sp_on !== 1'b1 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		rng(n, tk(spw[c]) - 2, tk(spw[c]) + 10);
		sp_req = 1'b0;
		@(negedge clk);
		@(negedge clk);
		chk(sp_on, 1'b0);
	endtask
	// all up, power-down pulse with requests still high
	task automatic pdn_run(input logic [7:0] v, input logic [1:0] x);
		int n;
		wr(8'h21, v);
		hp_req = 1'b1;
		sp_req = 1'b1;
		dac_req = 1'b1;
		n = 0;
		while (!(hp_on === 1'b1 && sp_on === 1'b1 && dac_en === 1'b1) &&
			n < 20000) begin
			@(negedge clk);
			n++;
		end
		chk({hp_on, sp_on, dac_en, hp_en}, 4'hf);
		pdn = 1'b1;
		@(negedge clk);
		pdn = 1'b0;
		chk({dac_en, busy}, x);
		n = 0;
		while (hp_en === 1'b1 && n < 20000) begin
			chk(dac_en, x[1]);
			@(negedge clk);
			n++;
		end
		n = 0;
		while (dac_en !== 1'b0 && n < 20) begin
			@(negedge clk);
			n++;
		end
		rng(n, 0, 3);
		hp_req = 1'b0;
		sp_req = 1'b0;
		dac_req = 1'b0;
		n = 0;
		while (busy !== 1'b0 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		chk(busy, 1'b0);
	endtask
	initial begin
		reset_n = 1'b0;
		addr = 8'h00;
		wr_en = 1'b0;
		wdata = 8'h00;
		rd_en = 1'b0;
		hp_req = 1'b0;
		sp_req = 1'b0;
		dac_req = 1'b0;
		pdn = 1'b0;
		void'($urandom(52238));
		repeat (2) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		rd(8'h00, 8'h00);
		rd(8'h21, 8'h00);
		wr(8'h23, 8'hff);
		@(negedge clk);
		chk(rt, 8'h00);
		wr(8'h00, 8'h01);
		rd(8'h00, 8'h01);
		rd(8'h21, 8'h3e);
		rd(8'h22, 8'h00);
		rd(8'h23, 8'h00);
		rd(8'h24, 8'h00);
		wr(8'h22, 8'h30);
		rd(8'h22, 8'h30);
		$display("test registers done");
		for (int i = 0; i < 12; i++) begin
			r = 8'($urandom);
			r[7:6] = i[1:0];
			r[3:2] = ~i[1:0];
			e = {r[7:6] == 2'h1, r[7:6] == 2'h2, r[3:2] == 2'h1,
				r[3:2] == 2'h2, r[5], r[4], r[1], r[0]};
			wr(8'h23, r);
			@(negedge clk);
			chk(rt, e);
			rd(8'h23, r);
		end
		$display("test routing done");
		for (int i = 0; i < 5; i++) begin
			hp_run({1'b0, 4'(i), 3'h0}, d, s);
			rng(d, tk(pon[i]) - 2, tk(pon[i]) + 12);
		end
		for (int i = 0; i < 4; i++) begin
			hp_run({5'h00, 2'(i), 1'b0}, d, s);
			rng(s, tk(stp[i]) - 2, tk(stp[i]) + 8);
		end
		$display("test headphone timing done");
		for (int i = 0; i < 8; i++)
			sp_run(3'(i));
		$display("test speaker wait done");
		wr(8'h22, 8'h00);
		pdn_run(8'h00, 2'b01);
		pdn_run(8'h84, 2'b11);
		$display("test power-down order done");
		finish_test();
	end
	// hang guard, well above the roughly 31k cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
endmodule
